// ### acpc_regs.svh
// Constants for the converter pin-control block: offsets, fields, resets, timing.
// Assumes inclusion by the design top and its bench only.
`ifndef ACPC_REGS_SVH
`define ACPC_REGS_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define ACPC_CTRL_ADDR 8'h00
`define ACPC_STAT_ADDR 8'h04
`define ACPC_DATA_ADDR 8'h08
`define ACPC_SAMP_ADDR 8'h0c

// ----------------------------------------
// Control fields
// ----------------------------------------
`define ACPC_CTRL_SPAN 0
`define ACPC_CTRL_SIGN 1
`define ACPC_CTRL_REFDIS 2
`define ACPC_CTRL_PD 3
`define ACPC_CTRL_CODING 4
`define ACPC_CTRL_RST 8'h10

// ----------------------------------------
// Status fields
// ----------------------------------------
`define ACPC_STAT_BUSY 0
`define ACPC_STAT_PDOWN 1
`define ACPC_STAT_REFEN 2
`define ACPC_STAT_RANGE_LO 3

// ----------------------------------------
// Timing
// ----------------------------------------
`define ACPC_CLK_MHZ 250
`define ACPC_CONV_NS 4000
`define ACPC_CONV_CYC ((`ACPC_CONV_NS * `ACPC_CLK_MHZ) / 1000)

`endif

// ### acpc_pkg.sv
// Types shared by the converter pin-control block.
// Assumes the constants header sits in the same folder.
package acpc_pkg;

  typedef enum logic [1:0] {
    ACPC_IDLE,
    ACPC_CONV,
    ACPC_PDOWN
  } acpc_state_e;

  typedef enum logic [1:0] {
    ACPC_U5,
    ACPC_U10,
    ACPC_B5,
    ACPC_B10
  } acpc_range_e;

endpackage

// ### acpc_top.sv
// Converter pin control: range select, output enable, reset, power-down, conversion.
// Assumes strobe pins are asynchronous and Wishbone is on clk_i.
// Operation
// (R1) Sign and span pins pick 0-5, 0-10, +-5 or +-10 V range.
// (R2) Output bus driven only while select and read strobes are both low.
// (R3) Reset high holds device in reset and aborts any conversion.
// (R4) Reset fall clears configuration and zeroes data, coding select high.
// (R5) Power-down lets current conversion finish, then blocks new ones.
// (R6) Host interface stays fully working while powered down.
// (R7) A convert-start falling edge while idle and not powered down holds the sample and begins conversion.
// (R8) Reference disable low enables internal reference and buffer, high disables.
// (R9) Busy rises at conversion start and falls when the result is latched.
// (R10) Host waits for busy to fall before reading the result.
`timescale 1ns/1ps
`include "acpc_regs.svh"

module acpc_top
  import acpc_pkg::*;
#(
  parameter int CONV_CYCLES = `ACPC_CONV_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic adc_reset_i,
  input wire logic sign_select_i,
  input wire logic range_span_select_i,
  input wire logic power_down_in_i,
  input wire logic convert_start_n_i,
  input wire logic chip_select_n_i,
  input wire logic read_n_i,
  input wire logic reference_buffer_disable_i,
  input wire logic [15:0] sample_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [15:0] data_o,
  output logic data_oe_o,
  output logic busy_o,
  output logic sample_hold_o,
  output logic output_coding_select_o,
  output logic [1:0] range_o,
  output logic reference_enable_o,
  output logic reduced_power_o
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  localparam int NP = 8;
  logic [NP-1:0] pin_raw;
  logic [NP-1:0] s1_reg, s2_reg, s3_reg, pin_reg;
  logic [NP-1:0] pin_next;
  assign pin_raw = {adc_reset_i, sign_select_i, range_span_select_i, power_down_in_i,
                    convert_start_n_i, chip_select_n_i, read_n_i,
                    reference_buffer_disable_i};
  always_comb begin
    pin_next = pin_reg;
    for (int i = 0; i < NP; i++) begin
      if (s2_reg[i] == s3_reg[i]) begin
        pin_next[i] = s3_reg[i];
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_reg <= 8'h0f;
      s2_reg <= 8'h0f;
      s3_reg <= 8'h0f;
      pin_reg <= 8'h0f;
    end else begin
      s1_reg <= pin_raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      pin_reg <= pin_next;
    end
  end
  logic arst, sgn, spn, pdn, cnv_n, cs_n, rd_n, refdis;
  assign {arst, sgn, spn, pdn, cnv_n, cs_n, rd_n, refdis} = pin_reg;

  // ----------------------------------------
  // Control state
  // ----------------------------------------
  acpc_state_e st_reg, st_next;
  logic [15:0] cnt_reg, cnt_next;
  logic [15:0] data_reg, data_next;
  logic [15:0] hold_reg, hold_next;
  logic [7:0] cfg_reg, cfg_next;
  logic cnv_d_reg, arst_d_reg, ack_reg, ack_next;
  logic [31:0] rd_reg, rd_next;
  logic cnv_fall, arst_fall, pd_eff, wb_req;

  assign cnv_fall = cnv_d_reg && !cnv_n;
  assign arst_fall = arst_d_reg && !arst;
  assign pd_eff = pdn || cfg_reg[`ACPC_CTRL_PD];
  assign wb_req = wb_cyc_i && wb_stb_i && !ack_reg;

  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    data_next = data_reg;
    hold_next = hold_reg;
    cfg_next = cfg_reg;
    if (arst) begin
      st_next = ACPC_IDLE; // R3
      cnt_next = 16'h0000;
    end else begin
      unique case (st_reg)
        ACPC_IDLE: begin
          if (pd_eff) begin
            st_next = ACPC_PDOWN; // R5
          end else if (cnv_fall) begin
            hold_next = sample_i; // R7
            cnt_next = CONV_CYCLES[15:0] - 16'h0001;
            st_next = ACPC_CONV;
          end
        end
        ACPC_CONV: begin
          if (cnt_reg == 16'h0000) begin
            data_next = hold_reg; // R9
            st_next = pd_eff ? ACPC_PDOWN : ACPC_IDLE; // R5
          end else begin
            cnt_next = cnt_reg - 16'h0001;
          end
        end
        ACPC_PDOWN: begin
          if (!pd_eff) begin
            st_next = ACPC_IDLE;
          end
        end
      endcase
    end
    if (arst_fall) begin
      cfg_next = `ACPC_CTRL_RST; // R4
      data_next = 16'h0000; // R4
    end else if (wb_req && wb_we_i && wb_adr_i == `ACPC_CTRL_ADDR && wb_sel_i[0]) begin
      cfg_next = wb_dat_i[7:0]; // R6
    end
  end

  // ----------------------------------------
  // Wishbone slave
  // ----------------------------------------
  always_comb begin
    ack_next = wb_req;
    rd_next = rd_reg;
    if (wb_req && !wb_we_i) begin
      unique case (wb_adr_i)
        `ACPC_CTRL_ADDR: rd_next = {24'h000000, cfg_reg};
        `ACPC_STAT_ADDR: rd_next = {27'h0000000, range_o, reference_enable_o,
                                   reduced_power_o, busy_o};
        `ACPC_DATA_ADDR: rd_next = {16'h0000, data_reg};
        `ACPC_SAMP_ADDR: rd_next = {16'h0000, hold_reg};
        default: rd_next = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= ACPC_IDLE;
      cnt_reg <= 16'h0000;
      data_reg <= 16'h0000;
      hold_reg <= 16'h0000;
      cfg_reg <= `ACPC_CTRL_RST;
      cnv_d_reg <= 1'b1;
      arst_d_reg <= 1'b0;
      ack_reg <= 1'b0;
      rd_reg <= 32'h00000000;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      data_reg <= data_next;
      hold_reg <= hold_next;
      cfg_reg <= cfg_next;
      cnv_d_reg <= cnv_n;
      arst_d_reg <= arst;
      ack_reg <= ack_next;
      rd_reg <= rd_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rd_reg;
  assign data_o = data_reg;
  assign data_oe_o = !cs_n && !rd_n; // R2
  assign busy_o = (st_reg == ACPC_CONV); // R9
  assign sample_hold_o = (st_reg == ACPC_CONV); // R7
  assign output_coding_select_o = cfg_reg[`ACPC_CTRL_CODING];
  assign range_o = {sgn | cfg_reg[`ACPC_CTRL_SIGN], spn | cfg_reg[`ACPC_CTRL_SPAN]}; // R1
  assign reference_enable_o = !(refdis || cfg_reg[`ACPC_CTRL_REFDIS]); // R8
  assign reduced_power_o = (st_reg == ACPC_PDOWN); // R5

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_oe_strobes: assert property (@(posedge clk_i) disable iff (rst_i)
    data_oe_o == (!cs_n && !rd_n)) else $error("output enable mismatch"); // R2
  a_reset_abort: assert property (@(posedge clk_i) disable iff (rst_i)
    arst |=> !busy_o) else $error("conversion survived reset"); // R3
  a_reset_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    arst_fall |=> (data_o == 16'h0000 && output_coding_select_o)) else $error("reset clear"); // R4
  a_pd_block: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_reg == ACPC_PDOWN && pd_eff) |=> !busy_o) else $error("conversion in power-down"); // R5
  a_pd_finish: assert property (@(posedge clk_i) disable iff (rst_i || arst)
    (busy_o && pd_eff && cnt_reg != 16'h0000) |=> busy_o) else $error("conversion cut"); // R5
  a_start_conv: assert property (@(posedge clk_i) disable iff (rst_i)
    (cnv_fall && st_reg == ACPC_IDLE && !pd_eff && !arst) |=> busy_o) else $error("no start"); // R7
  a_ref_enable: assert property (@(posedge clk_i) disable iff (rst_i)
    refdis |-> !reference_enable_o) else $error("reference not disabled"); // R8
  a_range_map: assert property (@(posedge clk_i) disable iff (rst_i)
    (sgn && spn) |-> range_o == ACPC_B10) else $error("range mapping"); // R1
  a_busy_latch: assert property (@(posedge clk_i) disable iff (rst_i || arst)
    $fell(busy_o) |-> data_o == hold_reg) else $error("busy fell without data"); // R9
  a_wb_ack: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_req |=> wb_ack_o ##1 !wb_ack_o) else $error("bus answer"); // R6
  c_conv_done: cover property (@(posedge clk_i) $fell(busy_o));
  c_pd_enter: cover property (@(posedge clk_i) $rose(reduced_power_o));
  c_read_oe: cover property (@(posedge clk_i) $rose(data_oe_o));
  c_reset_abort: cover property (@(posedge clk_i) busy_o && arst);

endmodule

// ### acpc_host.sv
// Host model that fetches each conversion result.
// Assumes busy_i comes from the converter on clk_i.
`timescale 1ns/1ps
module acpc_host (
  input wire logic clk_i,
  input wire logic busy_i,
  output logic chip_select_n_o,
  output logic read_n_o
);
  logic busy_reg = 1'b0;
  logic [3:0] cnt_reg = 4'h0;
  // Strobes low for twelve cycles once busy falls
  always_ff @(posedge clk_i) begin
    busy_reg <= busy_i;
    if (busy_reg && !busy_i) cnt_reg <= 4'hc;
    else if (cnt_reg != 4'h0) cnt_reg <= cnt_reg - 4'h1;
  end
  assign chip_select_n_o = (cnt_reg == 4'h0);
  assign read_n_o = (cnt_reg == 4'h0);
endmodule

// ### acpc_top_tb.sv
// Testbench of the converter pin-control block.
// Assumes the design package and constants header are in this folder.
`timescale 1ns/1ps
`include "acpc_regs.svh"
module acpc_top_tb;
  import acpc_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, ares = 1'b0, sgn = 1'b0, spn = 1'b0;
  logic pd = 1'b0, cnv_n = 1'b1, refd = 1'b0, cs_n, rd_n, cyc = 1'b0, we = 1'b0;
  logic [15:0] smp = 16'h0000;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, wb_dat_o;
  logic wb_ack_o, data_oe_o, busy_o, hold_o, code_o, refen_o, lowp_o;
  logic [15:0] data_o;
  logic [1:0] range_o;
  int mismatches = 0, checks_done = 0;
  always #2 clk_i = ~clk_i;
  acpc_top #(.CONV_CYCLES(20)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .adc_reset_i(ares),
    .sign_select_i(sgn), .range_span_select_i(spn), .power_down_in_i(pd),
    .convert_start_n_i(cnv_n), .chip_select_n_i(cs_n), .read_n_i(rd_n),
    .reference_buffer_disable_i(refd), .sample_i(smp), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .data_o(data_o), .data_oe_o(data_oe_o), .busy_o(busy_o),
    .sample_hold_o(hold_o), .output_coding_select_o(code_o), .range_o(range_o),
    .reference_enable_o(refen_o), .reduced_power_o(lowp_o));
  acpc_host host_u (.clk_i(clk_i), .busy_i(busy_o), .chip_select_n_o(cs_n), .read_n_o(rd_n));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    chk(wb_ack_o, 1'b1);
    rdat = wb_dat_o;
    cyc <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic waitb(input logic v);
    int n;
    n = 0;
    while (busy_o !== v && n < 40) begin
      @(posedge clk_i);
      n++;
    end
    chk(busy_o, v);
  endtask
  task automatic start(input logic [15:0] s);
    smp <= s;
    cnv_n <= 1'b0;
    waitb(1'b1);
    chk(hold_o, 1'b1);
    cnv_n <= 1'b1;
  endtask
  task automatic end_of_test();
    $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_range();
    for (int i = 0; i < 4; i++) begin
      {sgn, spn} <= i[1:0];
      refd <= i[0];
      repeat (6) @(posedge clk_i);
      chk(range_o, i[1:0]);
      chk(refen_o, !i[0]);
    end
  endtask
  task automatic t_conv();
    start(16'h1234);
    waitb(1'b0);
    chk(data_o, 16'h1234);
    repeat (8) @(posedge clk_i);
    chk(data_oe_o, 1'b1);
    repeat (12) @(posedge clk_i);
    chk(data_oe_o, 1'b0);
  endtask
  task automatic t_abort();
    wb(1'b1, `ACPC_CTRL_ADDR, 32'h1);
    start(16'h5a5a);
    ares <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk(busy_o, 1'b0);
    chk(data_o, 16'h1234);
    ares <= 1'b0;
    repeat (8) @(posedge clk_i);
    chk(data_o, 16'h0);
    chk(code_o, 1'b1);
    wb(1'b0, `ACPC_CTRL_ADDR, 32'h0);
    chk(rdat, 32'h10);
  endtask
  task automatic t_pd();
    start(16'h0f0f);
    pd <= 1'b1;
    repeat (6) @(posedge clk_i);
    chk(busy_o, 1'b1);
    waitb(1'b0);
    chk(data_o, 16'h0f0f);
    repeat (6) @(posedge clk_i);
    chk(lowp_o, 1'b1);
    cnv_n <= 1'b0;
    repeat (12) @(posedge clk_i);
    chk(busy_o, 1'b0);
    cnv_n <= 1'b1;
    wb(1'b0, `ACPC_STAT_ADDR, 32'h0);
    chk(rdat[1], 1'b1);
    wb(1'b0, `ACPC_DATA_ADDR, 32'h0);
    chk(rdat, 32'h0f0f);
    wb(1'b0, 8'h20, 32'h0);
    chk(rdat, 32'h0);
    pd <= 1'b0;
  endtask
  initial begin
    #40000;
    mismatches++;
    end_of_test();
  end
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, `ACPC_CTRL_ADDR, 32'h0);
    chk(rdat, 32'h10);
    chk(data_o, 16'h0);
    t_range();
    t_conv();
    t_abort();
    t_pd();
    end_of_test();
  end
endmodule
